/* core/tocu_pkg.sv */
package tocu_pkg;

   localparam logic [7:0] TOCU_BOTTOM     = 8'h00;
   localparam logic [7:0] TOCU_MAX        = 8'hFF;
   localparam logic [7:0] TOCU_COUNT_RST  = 8'h00;
   localparam logic [7:0] TOCU_CMP_RST    = 8'h00;

   localparam logic [1:0] TOCU_ACT_NONE   = 2'h0;
   localparam logic [1:0] TOCU_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] TOCU_ACT_CLEAR  = 2'h2;
   localparam logic [1:0] TOCU_ACT_SET    = 2'h3;

   typedef enum logic [1:0] {
      TOCU_WGM_NORMAL = 2'b00,
      TOCU_WGM_PCPWM  = 2'b01,
      TOCU_WGM_CTC    = 2'b10,
      TOCU_WGM_FPWM   = 2'b11
   } tocu_wgm_t;

   typedef struct packed {
      tocu_wgm_t  waveform_mode_select;
      logic [1:0] output_action_bits;
      logic       compare_irq_enable;
   } tocu_ctrl_t;

   typedef struct packed {
      logic       wr_en;
      logic [7:0] wr_data;
   } tocu_wr_t;

endpackage

/* core/tocu_comparator.sv */
`timescale 1ns/1ps
module tocu_comparator (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Compare inputs
   input  wire logic [7:0] count,
   input  wire logic [7:0] compare,
   input  wire logic       block_next,
   // Result
   output logic            match
);
   import tocu_pkg::*;

   logic block_reg;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         block_reg <= 1'b0;
      end else if (clk_en) begin
         block_reg <= block_next;
      end
   end

   assign match = (count == compare) && !block_reg;

endmodule

/* core/tocu_output_latch.sv */
`timescale 1ns/1ps
module tocu_output_latch (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Control
   input  wire logic       pwm_mode,
   input  wire logic [1:0] action,
   input  wire logic       event_hit,
   // Latch
   output logic            latch_q
);
   import tocu_pkg::*;

   logic latch_reg;
   logic latch_next;

   always_comb begin
      latch_next = latch_reg;
      if (event_hit && !pwm_mode) begin
         unique case (action)
            TOCU_ACT_NONE:   latch_next = latch_reg;
            TOCU_ACT_TOGGLE: latch_next = !latch_reg;
            TOCU_ACT_CLEAR:  latch_next = 1'b0;
            TOCU_ACT_SET:    latch_next = 1'b1;
         endcase
      end
   end

   // Mode change leaves latch untouched
   always_ff @(posedge core_clk) begin
      if (rst) begin
         latch_reg <= 1'b0;
      end else if (clk_en) begin
         latch_reg <= latch_next;
      end
   end

   assign latch_q = latch_reg;

endmodule

/* core/tocu_top.sv */
// Behaviour
// - Compare on each tick; flag set two cycles later.
// - Interrupt request while flag and enable.
// - Flag cleared by service or write-one.
// - PWM modes buffer compare; FPWM loads at wrap from max, PCPWM on reaching max.
// - Writes hit buffer or active register.
// - Force strobe updates latch in non-PWM modes, no flag.
// - Counter write blocks next-cycle matches.
// - Latch keeps level across mode changes.
// - Action bits act immediately, unbuffered.
// - Nonzero action overrides port output value.
// - Action zero leaves latch unchanged.
// - Counting depends only on mode bits.
// - Action bits: set/clear/toggle or polarity.
// - Normal mode counts up, wraps to zero.
// - Overflow flag set on wrap from max to zero, or on down-count to zero in PCPWM.
// - Counter writable any time in normal mode.
// - Counter write beats count and clear.
// - Bottom is 0x00, max is 0xFF.
// - Action one toggles latch in non-PWM.
`timescale 1ns/1ps
module tocu_top (
   // Clock, reset, enable
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                clk_en,
   // Timer clock tick
   input  wire logic                timer_tick,
   // Control bits
   input  wire tocu_pkg::tocu_ctrl_t ctrl,
   input  wire logic                output_pin_direction_bit,
   input  wire logic                port_out_value,
   // CPU writes
   input  wire tocu_pkg::tocu_wr_t  count_wr,
   input  wire tocu_pkg::tocu_wr_t  compare_wr,
   input  wire logic                force_compare_strobe,
   input  wire logic                match_flag_wr_one,
   input  wire logic                overflow_flag_wr_one,
   input  wire logic                compare_irq_ack,
   input  wire logic                overflow_irq_ack,
   // Status
   output logic [7:0]               timer_count_value,
   output logic [7:0]               compare_value,
   output logic [7:0]               compare_active,
   output logic                     compare_match_flag,
   output logic                     overflow_flag,
   output logic                     compare_irq,
   output logic                     compare_output_latch,
   // Pin
   output logic                     pin_out,
   output logic                     pin_oe_n
);
   import tocu_pkg::*;

   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic       dir_down_reg;
   logic [7:0] buf_reg;
   logic [7:0] active_reg;
   logic       match_flag_reg;
   logic       ovf_flag_reg;
   logic       irq_reg;
   logic       pin_out_reg;
   logic       pin_oe_n_reg;
   logic       latch_q;
   logic       match;
   logic       match_d_reg;
   logic       pwm_mode;
   logic       at_bottom_next;
   logic       ovf_event;
   logic       match_tick;
   logic       latch_event;
   logic       load_active;
   logic       blk_hold_reg;
   logic       blk_next;
   logic       pin_src;

   assign pwm_mode = (ctrl.waveform_mode_select == TOCU_WGM_PCPWM) ||
                     (ctrl.waveform_mode_select == TOCU_WGM_FPWM);

   always_comb begin
      count_next = count_reg;
      unique case (ctrl.waveform_mode_select)
         TOCU_WGM_NORMAL: count_next = count_reg + 8'h01;
         TOCU_WGM_CTC: begin
            if (match) begin
               count_next = TOCU_BOTTOM;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end
         TOCU_WGM_FPWM: count_next = count_reg + 8'h01;
         TOCU_WGM_PCPWM: begin
            if (dir_down_reg) begin
               count_next = count_reg - 8'h01;
            end else begin
               count_next = count_reg + 8'h01;
            end
         end
      endcase
   end

   assign at_bottom_next = (count_next == TOCU_BOTTOM);
   assign ovf_event  = timer_tick && !count_wr.wr_en &&
                       (((ctrl.waveform_mode_select != TOCU_WGM_PCPWM) &&
                         count_reg == TOCU_MAX) ||
                        ((ctrl.waveform_mode_select == TOCU_WGM_PCPWM) &&
                         dir_down_reg && at_bottom_next));
   assign match_tick = match && timer_tick;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= TOCU_COUNT_RST;
      end else if (clk_en) begin
         if (count_wr.wr_en) begin
            count_reg <= count_wr.wr_data;
         end else if (timer_tick) begin
            count_reg <= count_next;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         dir_down_reg <= 1'b0;
      end else if (clk_en) begin
         if (ctrl.waveform_mode_select != TOCU_WGM_PCPWM) begin
            dir_down_reg <= 1'b0;
         end else if (timer_tick && !count_wr.wr_en) begin
            if (count_next == TOCU_MAX) begin
               dir_down_reg <= 1'b1;
            end else if (at_bottom_next) begin
               dir_down_reg <= 1'b0;
            end
         end
      end
   end

   assign load_active = timer_tick && !count_wr.wr_en &&
      (((ctrl.waveform_mode_select == TOCU_WGM_FPWM) &&
        count_reg == TOCU_MAX) ||
       ((ctrl.waveform_mode_select == TOCU_WGM_PCPWM) &&
        count_next == TOCU_MAX));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         buf_reg <= TOCU_CMP_RST;
      end else if (clk_en) begin
         if (compare_wr.wr_en) begin
            buf_reg <= compare_wr.wr_data;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         active_reg <= TOCU_CMP_RST;
      end else if (clk_en) begin
         if (!pwm_mode && compare_wr.wr_en) begin
            active_reg <= compare_wr.wr_data;
         end else if (!pwm_mode) begin
            active_reg <= buf_reg;
         end else if (load_active) begin
            active_reg <= buf_reg;
         end
      end
   end

   // block until next tick
   // A stopped timer keeps the block armed until its next tick
   assign blk_next = count_wr.wr_en || (blk_hold_reg && !timer_tick);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         blk_hold_reg <= 1'b0;
      end else if (clk_en) begin
         blk_hold_reg <= blk_next;
      end
   end

   tocu_comparator u_cmp (
      .core_clk   (core_clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .count      (count_reg),
      .compare    (active_reg),
      .block_next (blk_next),
      .match      (match)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         match_d_reg <= 1'b0;
      end else if (clk_en) begin
         match_d_reg <= match_tick;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         match_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (match_d_reg) begin
            match_flag_reg <= 1'b1;
         end else if (compare_irq_ack || match_flag_wr_one) begin
            match_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ovf_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (ovf_event) begin
            ovf_flag_reg <= 1'b1;
         end else if (overflow_irq_ack || overflow_flag_wr_one) begin
            ovf_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else if (clk_en) begin
         irq_reg <= ctrl.compare_irq_enable && match_flag_reg;
      end
   end

   assign latch_event = match_tick || (force_compare_strobe && !pwm_mode);

   tocu_output_latch u_latch (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .pwm_mode  (pwm_mode),
      .action    (ctrl.output_action_bits),
      .event_hit (latch_event),
      .latch_q   (latch_q)
   );

   always_comb begin
      if (ctrl.output_action_bits == TOCU_ACT_NONE) begin
         pin_src = port_out_value;
      end else if (pwm_mode &&
                   ctrl.output_action_bits == TOCU_ACT_SET) begin
         pin_src = !latch_q;
      end else begin
         pin_src = latch_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_oe_n_reg <= 1'b1;
      end else if (clk_en) begin
         pin_oe_n_reg <= !output_pin_direction_bit;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_out_reg <= 1'b0;
      end else if (clk_en) begin
         pin_out_reg <= pin_src;
      end
   end

   assign timer_count_value    = count_reg;
   assign compare_value        = buf_reg;
   assign compare_active       = active_reg;
   assign compare_match_flag   = match_flag_reg;
   assign overflow_flag        = ovf_flag_reg;
   assign compare_irq          = irq_reg;
   assign compare_output_latch = latch_q;
   assign pin_out              = pin_out_reg;
   assign pin_oe_n             = pin_oe_n_reg;

endmodule

/* tb/tocu_top_checker.sv */
`timescale 1ns/1ps
module tocu_top_checker import tocu_pkg::*; (
   // Block inputs
   input logic                 core_clk,
   input logic                 rst,
   input logic                 clk_en,
   input logic                 timer_tick,
   input tocu_pkg::tocu_ctrl_t ctrl,
   input logic                 output_pin_direction_bit,
   input logic                 port_out_value,
   input tocu_pkg::tocu_wr_t   count_wr,
   input logic                 force_compare_strobe,
   input logic                 match_flag_wr_one,
   input logic                 compare_irq_ack,
   // Block outputs
   input logic [7:0]           timer_count_value,
   input logic [7:0]           compare_active,
   input logic                 compare_match_flag,
   input logic                 overflow_flag,
   input logic                 compare_irq,
   input logic                 compare_output_latch,
   input logic                 pin_out,
   input logic                 pin_oe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst || !clk_en);
   logic eq;
   logic blk_reg;
   assign eq = timer_count_value == compare_active;
   // Counter write blocks matches up to and including the next tick
   always_ff @(posedge core_clk) begin
      if (rst) begin
         blk_reg <= 1'b0;
      end else if (clk_en) begin
         blk_reg <= count_wr.wr_en || (blk_reg && !timer_tick);
      end
   end
   sequence s_norm_step;
      ctrl.waveform_mode_select == TOCU_WGM_NORMAL && timer_tick
         && !count_wr.wr_en;
   endsequence
   sequence s_live_match;
      eq && timer_tick && !blk_reg;
   endsequence
   property p_flag_set;
      s_live_match |-> ##[1:3] compare_match_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("match did not set flag");
   property p_irq_req;
      compare_match_flag && ctrl.compare_irq_enable |=> compare_irq;
   endproperty
   a_irq_req: assert property (p_irq_req)
      else $error("no interrupt request");
   property p_flag_clr;
      (compare_irq_ack || match_flag_wr_one) && !eq && !$past(eq)
         && !$past(eq, 2) |=> !compare_match_flag;
   endproperty
   a_flag_clr: assert property (p_flag_clr)
      else $error("flag not cleared");
   property p_cnt_wr;
      count_wr.wr_en |=> timer_count_value == $past(count_wr.wr_data);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr)
      else $error("counter write lost");
   property p_cnt_step;
      s_norm_step |=> timer_count_value == $past(timer_count_value) + 8'h01;
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("counter did not step up");
   property p_ovf;
      s_norm_step ##0 timer_count_value == TOCU_MAX
         |=> timer_count_value == TOCU_BOTTOM && overflow_flag;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("wrap or overflow wrong");
   property p_pin;
      1'b1 |=> pin_oe_n == !$past(output_pin_direction_bit)
         && pin_out == (($past(ctrl.output_action_bits) == TOCU_ACT_NONE) ?
         $past(port_out_value) :
         (($past(ctrl.waveform_mode_select[0]) &&
           $past(ctrl.output_action_bits) == TOCU_ACT_SET) ?
          !$past(compare_output_latch) : $past(compare_output_latch)));
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin value or enable wrong");
   property p_act_none;
      (ctrl.output_action_bits == TOCU_ACT_NONE) [*3]
         |-> $stable(compare_output_latch);
   endproperty
   a_act_none: assert property (p_act_none)
      else $error("latch moved with no action");
   property p_force_set;
      force_compare_strobe && !ctrl.waveform_mode_select[0]
         && ctrl.output_action_bits == TOCU_ACT_SET
         |-> ##[1:2] compare_output_latch;
   endproperty
   a_force_set: assert property (p_force_set)
      else $error("force did not set latch");
   property p_pwm_hold;
      ctrl.waveform_mode_select[0] [*3] |-> $stable(compare_output_latch);
   endproperty
   a_pwm_hold: assert property (p_pwm_hold)
      else $error("latch moved in pwm mode");
endmodule
bind tocu_top tocu_top_checker u_tocu_top_checker (.*);

/* tb/tocu_cpu_model.sv */
`timescale 1ns/1ps
module tocu_cpu_model (
   // Clock
   input  logic               core_clk,
   // Writes and strobes
   output tocu_pkg::tocu_wr_t count_wr,
   output tocu_pkg::tocu_wr_t compare_wr,
   output logic [4:0]         strobes
);
   import tocu_pkg::*;
   initial begin
      count_wr = '0;
      compare_wr = '0;
      strobes = '0;
   end
   task automatic wr(input logic sel, input logic [7:0] v);
      @(negedge core_clk);
      if (sel) begin
         count_wr = {1'b1, v};
      end else begin
         compare_wr = {1'b1, v};
      end
      @(negedge core_clk);
      count_wr.wr_en = 1'b0;
      compare_wr.wr_en = 1'b0;
   endtask
   task automatic pulse(input logic [4:0] s);
      @(negedge core_clk);
      strobes = s;
      @(negedge core_clk);
      strobes = '0;
   endtask
endmodule

/* tb/tb_timer8_output_compare_unit.sv */
`timescale 1ns/1ps
module tb_timer8_output_compare_unit;
   import tocu_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst = 1'b1;
   logic       en = 1'b1;
   logic       tick = 1'b0;
   tocu_ctrl_t ctrl = '0;
   logic       dir = 1'b0;
   logic       port = 1'b0;
   tocu_wr_t   cnt_w, cmp_w;
   logic [4:0] stb;
   logic [7:0] cnt, cmp_v, cmp_a;
   logic       mflag, oflag, irq, latch, pin, oe_n;
   int         miscompares = 0;
   int         cmp_count = 0;
   logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
   logic       exps [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   tocu_cpu_model u_tocu_cpu_model (.core_clk(core_clk),
      .count_wr(cnt_w), .compare_wr(cmp_w), .strobes(stb));
   tocu_top u_tocu_top (.core_clk(core_clk), .rst(rst), .clk_en(en),
      .timer_tick(tick), .ctrl(ctrl), .output_pin_direction_bit(dir),
      .port_out_value(port), .count_wr(cnt_w), .compare_wr(cmp_w),
      .force_compare_strobe(stb[4]), .match_flag_wr_one(stb[3]),
      .overflow_flag_wr_one(stb[2]), .compare_irq_ack(stb[1]),
      .overflow_irq_ack(stb[0]), .timer_count_value(cnt),
      .compare_value(cmp_v), .compare_active(cmp_a),
      .compare_match_flag(mflag), .overflow_flag(oflag),
      .compare_irq(irq), .compare_output_latch(latch), .pin_out(pin),
      .pin_oe_n(oe_n));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic step(input int n);
      tick = 1'b1;
      cyc(n);
      tick = 1'b0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      complete_run;
   end
   initial begin
      cyc(10);
      rst = 1'b0;
      chk("count", TOCU_BOTTOM, cnt);
      chk("pin_oe_n", 1'b1, oe_n);
      ctrl.compare_irq_enable = 1'b1;
      u_tocu_cpu_model.wr(1'b0, 8'h10);
      chk("compare_active", 8'h10, cmp_a);
      u_tocu_cpu_model.wr(1'b1, 8'hFD);
      step(3);
      chk("count", 8'h00, cnt);
      chk("overflow_flag", 1'b1, oflag);
      u_tocu_cpu_model.pulse(5'b00001);
      chk("overflow_flag", 1'b0, oflag);
      step(17);
      cyc(3);
      chk("match_flag", 1'b1, mflag);
      chk("irq", 1'b1, irq);
      u_tocu_cpu_model.pulse(5'b00010);
      chk("match_flag", 1'b0, mflag);
      cyc(1);
      chk("irq", 1'b0, irq);
      u_tocu_cpu_model.wr(1'b1, 8'h0F);
      step(2);
      cyc(3);
      chk("match_flag", 1'b1, mflag);
      u_tocu_cpu_model.pulse(5'b01000);
      chk("match_flag", 1'b0, mflag);
      u_tocu_cpu_model.wr(1'b0, 8'h20);
      u_tocu_cpu_model.wr(1'b1, 8'h20);
      step(1);
      cyc(3);
      chk("match_flag", 1'b0, mflag);
      chk("count", 8'h21, cnt);
      for (int i = 0; i < 5; i++) begin
         ctrl.output_action_bits = acts[i];
         u_tocu_cpu_model.pulse(5'b10000);
         cyc(1);
         chk("latch", exps[i], latch);
         chk("match_flag", 1'b0, mflag);
      end
      dir = 1'b1;
      port = 1'b1;
      cyc(2);
      chk("pin_out", 1'b1, pin);
      ctrl.output_action_bits = TOCU_ACT_TOGGLE;
      cyc(2);
      chk("pin_out", 1'b0, pin);
      chk("pin_oe_n", 1'b0, oe_n);
      ctrl.output_action_bits = TOCU_ACT_SET;
      u_tocu_cpu_model.pulse(5'b10000);
      cyc(1);
      ctrl.waveform_mode_select = TOCU_WGM_FPWM;
      ctrl.output_action_bits = TOCU_ACT_CLEAR;
      u_tocu_cpu_model.pulse(5'b10000);
      cyc(1);
      chk("latch", 1'b1, latch);
      u_tocu_cpu_model.wr(1'b0, 8'h40);
      chk("compare_value", 8'h40, cmp_v);
      chk("compare_active", 8'h20, cmp_a);
      u_tocu_cpu_model.wr(1'b1, 8'hFE);
      step(3);
      cyc(1);
      chk("compare_active", 8'h40, cmp_a);
      ctrl.waveform_mode_select = TOCU_WGM_NORMAL;
      u_tocu_cpu_model.wr(1'b0, 8'h50);
      chk("compare_active", 8'h50, cmp_a);
      chk("latch", 1'b1, latch);
      en = 1'b0;
      step(2);
      en = 1'b1;
      chk("count", 8'h01, cnt);
      u_tocu_cpu_model.pulse(5'b00100);
      chk("overflow_flag", 1'b0, oflag);
      ctrl.compare_irq_enable = 1'b0;
      u_tocu_cpu_model.wr(1'b1, 8'h4E);
      step(3);
      cyc(3);
      chk("match_flag", 1'b1, mflag);
      chk("irq", 1'b0, irq);
      chk("latch", 1'b0, latch);
      u_tocu_cpu_model.pulse(5'b01000);
      chk("match_flag", 1'b0, mflag);
      ctrl.waveform_mode_select = TOCU_WGM_CTC;
      ctrl.output_action_bits = TOCU_ACT_TOGGLE;
      u_tocu_cpu_model.wr(1'b1, 8'h4E);
      step(4);
      chk("count", 8'h01, cnt);
      chk("latch", 1'b1, latch);
      ctrl.waveform_mode_select = TOCU_WGM_PCPWM;
      u_tocu_cpu_model.wr(1'b0, 8'h60);
      chk("compare_active", 8'h50, cmp_a);
      u_tocu_cpu_model.wr(1'b1, 8'hFD);
      step(4);
      chk("count", 8'hFD, cnt);
      chk("compare_active", 8'h60, cmp_a);
      complete_run;
   end
endmodule
